/* File: rtl/es_health_ctrl.sv */
// Purpose: Health tests, start-up self-test and status control of an
//          entropy source, with a 32-bit Avalon-MM register slave.
// Assumes: Noise samples arrive synchronous to mclk_i, one per
//          noise_valid_i pulse.
// Notes:   Each access takes two cycles; see register map in defines.
//
// What this block does
// - Self-test runs after every reset, never on a software request.
// - During start-up self-test status reads self-test, data field zero.
// - A failing start-up self-test moves the block to fatal.
// - Continuous test or sensor error stops the main random output; the raw noise port stays live when enabled.
// - Non-critical alarm moves a live state back to self-test.
// - Critical failure moves straight to fatal, no intermediate state.
// - Health counters and references are never readable.
// - Window hit count zeroized every window; all health state by reset.
// - Any hardware test failure ends at least in self-test.
// - Each read returning random data wipes the output word.
// - Valid status and data only for a complete conditioned word.
// - Raw noise test port and main output never live together.
// - Status field: 11 fatal, 00 self-test.
// - Sixteen random bits per read, in the low bits.
// - Repeat counter restarts on change; cutoff raises alarm or fatal.
// - Every W'th sample is a reference counted over the rest of its own window.
`timescale 1ns/1ps
`default_nettype none
`include "es_health_defines.svh"

module es_health_ctrl (
   input  wire logic                   mclk_i,
   input  wire logic                   rst_n_i,
   input  wire logic [4:0]             address_i,
   input  wire logic                   read_i,
   input  wire logic                   write_i,
   input  wire logic [31:0]            writedata_i,
   output logic      [31:0]            readdata_o,
   output logic                        waitrequest_o,
   input  wire logic [`SAMPLE_W-1:0]   noise_i,
   input  wire logic                   noise_valid_i,
   input  wire logic                   env_alarm_i,
   output logic                        irq_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   es_health_pkg::es_state_t   state_reg;
   es_health_pkg::es_state_t   state_next;
   logic                       boot_reg;
   logic [10:0]                pass_cnt_reg;
   logic [`SAMPLE_W-1:0]       last_reg;
   logic [7:0]                 rep_cnt_reg;
   logic [8:0]                 win_cnt_reg;
   logic [`SAMPLE_W-1:0]       ref_reg;
   logic [9:0]                 hit_cnt_reg;
   logic [`RAND_W-1:0]         acc_reg;
   logic [3:0]                 bit_cnt_reg;
   logic [`RAND_W-1:0]         word_reg;
   logic [`SAMPLE_W-1:0]       noise_reg;
   logic                       test_en_reg;
   logic [`EVT_W-1:0]          evt_reg;
   logic [`EVT_W-1:0]          mask_reg;
   logic [`EVT_W-1:0]          evt_set;
   logic [`EVT_W-1:0]          evt_rd_reg;
   logic                       wipe_pend_reg;
   logic                       rep_alarm;
   logic                       rep_fatal;
   logic                       win_alarm;
   logic                       alarm;
   logic                       fatal;
   logic                       word_done;
   logic                       req;
   logic                       done;
   logic [31:0]                rd_mux;

   function automatic logic [1:0] operational_status_field_of(input es_health_pkg::es_state_t s);
      unique case (s)
         es_health_pkg::ST_SELFTEST: operational_status_field_of = `OPERATIONAL_STATUS_FIELD_SELFTEST;
         es_health_pkg::ST_WAIT:     operational_status_field_of = `OPERATIONAL_STATUS_FIELD_WAIT;
         es_health_pkg::ST_VALID:    operational_status_field_of = `OPERATIONAL_STATUS_FIELD_VALID;
         default:                    operational_status_field_of = `OPERATIONAL_STATUS_FIELD_FATAL;
      endcase
   endfunction

   function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
      hit = (a == ofs);
   endfunction

   // ----------------------------------------------------------------
   // Avalon-MM handshake
   // ----------------------------------------------------------------
   // Request seen with waitrequest high: answer next cycle. The edge
   // with waitrequest low is the one where the access takes effect.
   assign req  = read_i | write_i;
   assign done = req & ~waitrequest_o;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         waitrequest_o <= 1'b1;
      end else begin
         waitrequest_o <= ~(req & waitrequest_o);
      end
   end

   // Only status, flags, mask, control and gated data are muxed here.
   // private counters
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit(address_i, `OFS_SEED)) begin
         rd_mux[`OPERATIONAL_STATUS_FIELD_HI:`OPERATIONAL_STATUS_FIELD_LO] = operational_status_field_of(state_reg);
         if (state_reg == es_health_pkg::ST_VALID) begin
            rd_mux[`RAND_W-1:0] = word_reg;
         end
      end else if (hit(address_i, `OFS_EVT_STATUS)) begin
         rd_mux[`EVT_W-1:0] = evt_reg;
      end else if (hit(address_i, `OFS_EVT_MASK)) begin
         rd_mux[`EVT_W-1:0] = mask_reg;
      end else if (hit(address_i, `OFS_CTRL)) begin
         rd_mux[`CTRL_TEST_EN] = test_en_reg;
      end else if (hit(address_i, `OFS_NOISE)) begin
         if (test_en_reg) begin
            rd_mux[`SAMPLE_W-1:0] = noise_reg;
         end
      end
   end

   // Data and side-effect flags are captured together so that the wipe
   // and the clear act on exactly what the master is given.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         readdata_o    <= 32'h0000_0000;
         evt_rd_reg    <= 4'h0;
         wipe_pend_reg <= 1'b0;
      end else if (read_i & waitrequest_o) begin
         readdata_o    <= rd_mux;
         evt_rd_reg    <= hit(address_i, `OFS_EVT_STATUS) ? evt_reg : 4'h0;
         wipe_pend_reg <= hit(address_i, `OFS_SEED) &
                          (state_reg == es_health_pkg::ST_VALID);
      end else if (done) begin
         evt_rd_reg    <= 4'h0;
         wipe_pend_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Control and mask registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_reg    <= `EVT_MASK_RST;
         test_en_reg <= 1'b0;
      end else if (done & write_i) begin
         if (hit(address_i, `OFS_EVT_MASK)) begin
            mask_reg <= writedata_i[`EVT_W-1:0];
         end
         if (hit(address_i, `OFS_CTRL)) begin
            test_en_reg <= writedata_i[`CTRL_TEST_EN];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         noise_reg <= 8'h00;
      end else if (!test_en_reg) begin
         noise_reg <= 8'h00;
      end else if (noise_valid_i) begin
         noise_reg <= noise_i;
      end
   end

   // ----------------------------------------------------------------
   // Repetition test
   // ----------------------------------------------------------------
   // repeat cutoffs
   assign rep_alarm = noise_valid_i & (noise_i == last_reg) &
                      (rep_cnt_reg + 8'h01 == `REP_ALARM_CUT);
   assign rep_fatal = noise_valid_i & (noise_i == last_reg) &
                      (rep_cnt_reg + 8'h01 == `REP_FATAL_CUT);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last_reg    <= 8'h00;
         rep_cnt_reg <= 8'h00;
      end else if (noise_valid_i) begin
         last_reg <= noise_i;
         if (noise_i != last_reg) begin
            rep_cnt_reg <= 8'h00;
         end else if (rep_cnt_reg != 8'hFF) begin
            rep_cnt_reg <= rep_cnt_reg + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Window test
   // ----------------------------------------------------------------
   assign win_alarm = noise_valid_i & (win_cnt_reg != 9'h000) &
                      (noise_i == ref_reg) &
                      (hit_cnt_reg + 10'h001 == `WIN_CUT);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         win_cnt_reg <= 9'h000;
         ref_reg     <= 8'h00;
         hit_cnt_reg <= 10'h000;
      end else if (noise_valid_i) begin
         win_cnt_reg <= win_cnt_reg + 9'h001;
         if (win_cnt_reg == 9'h000) begin
            ref_reg     <= noise_i;
            hit_cnt_reg <= 10'h000;
         end else if (noise_i == ref_reg && hit_cnt_reg != 10'h3FF) begin
            hit_cnt_reg <= hit_cnt_reg + 10'h001;
         end
      end
   end

   // Critical: repeat fatal cutoff or sensor; non-critical otherwise.
   // error stops
   assign fatal = rep_fatal | env_alarm_i;
   assign alarm = rep_alarm | win_alarm;

   // ----------------------------------------------------------------
   // Conditioner
   // ----------------------------------------------------------------
   // One bit per sample by parity fold; a word counts only when all
   // sixteen bits were gathered in the waiting state.
   assign word_done = noise_valid_i & ~alarm & ~fatal &
                      (state_reg == es_health_pkg::ST_WAIT) &
                      ~test_en_reg & (bit_cnt_reg == 4'hF);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_reg     <= 16'h0000;
         bit_cnt_reg <= 4'h0;
      end else if (state_reg != es_health_pkg::ST_WAIT || test_en_reg) begin
         acc_reg     <= 16'h0000;
         bit_cnt_reg <= 4'h0;
      end else if (noise_valid_i) begin
         acc_reg     <= {acc_reg[`RAND_W-2:0], ^noise_i};
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         word_reg <= 16'h0000;
      end else if (word_done) begin
         word_reg <= {acc_reg[`RAND_W-2:0], ^noise_i};
      end else if (state_next != es_health_pkg::ST_VALID) begin
         word_reg <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Status state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         es_health_pkg::ST_SELFTEST: begin
            if (fatal || (alarm && boot_reg)) begin
               state_next = es_health_pkg::ST_FATAL;
            end else if (noise_valid_i && !alarm &&
                         pass_cnt_reg == `START_SAMPLES - 11'h001) begin
               state_next = es_health_pkg::ST_WAIT;
            end
         end
         es_health_pkg::ST_WAIT, es_health_pkg::ST_VALID: begin
            if (fatal) begin
               state_next = es_health_pkg::ST_FATAL;
            end else if (alarm) begin
               state_next = es_health_pkg::ST_SELFTEST;
            end else if (word_done) begin
               state_next = es_health_pkg::ST_VALID;
            end else if (state_reg == es_health_pkg::ST_VALID &&
                         ((done && wipe_pend_reg) || test_en_reg)) begin
               state_next = es_health_pkg::ST_WAIT;
            end
         end
         es_health_pkg::ST_FATAL: state_next = es_health_pkg::ST_FATAL;
         default: state_next = es_health_pkg::ST_FATAL;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= es_health_pkg::ST_SELFTEST;
      end else begin
         state_reg <= state_next;
      end
   end

   // Boot flag marks the start-up run; the pass counter restarts on
   // every alarm so recovery needs a full clean run.
   // self-test period
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         boot_reg     <= 1'b1;
         pass_cnt_reg <= 11'h000;
      end else begin
         if (state_reg == es_health_pkg::ST_SELFTEST &&
             state_next == es_health_pkg::ST_WAIT) begin
            boot_reg <= 1'b0;
         end
         if (state_reg != es_health_pkg::ST_SELFTEST || alarm) begin
            pass_cnt_reg <= 11'h000;
         end else if (noise_valid_i) begin
            pass_cnt_reg <= pass_cnt_reg + 11'h001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------
   always_comb begin
      evt_set                 = 4'h0;
      evt_set[`EVT_ALARM]     = (state_reg != es_health_pkg::ST_FATAL) &
                                (state_next == es_health_pkg::ST_SELFTEST) &
                                (state_reg != es_health_pkg::ST_SELFTEST);
      evt_set[`EVT_FATAL]     = (state_reg != es_health_pkg::ST_FATAL) &
                                (state_next == es_health_pkg::ST_FATAL);
      evt_set[`EVT_READY]     = word_done;
      evt_set[`EVT_TEST_DONE] = (state_reg == es_health_pkg::ST_SELFTEST) &
                                (state_next == es_health_pkg::ST_WAIT);
   end

   // Set wins over the read-clear in the same cycle.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evt_reg <= 4'h0;
      end else begin
         evt_reg <= (evt_reg & ~(done ? evt_rd_reg : 4'h0)) | evt_set;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(evt_reg & mask_reg);
      end
   end

endmodule // es_health_ctrl
`default_nettype wire

/* File: rtl/es_health_defines.svh */
// Purpose: Offsets, field positions, reset values and counts of the
//          entropy source health and status control block.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave.
// Notes:   Definitions only.
`ifndef ES_HEALTH_DEFINES_SVH
`define ES_HEALTH_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_SEED        5'h00
`define OFS_EVT_STATUS  5'h04
`define OFS_EVT_MASK    5'h08
`define OFS_CTRL        5'h0C
`define OFS_NOISE       5'h10

// ----------------------------------------------------------------
// Field positions and encodings
// ----------------------------------------------------------------
`define OPERATIONAL_STATUS_FIELD_HI         31
`define OPERATIONAL_STATUS_FIELD_LO         30
`define OPERATIONAL_STATUS_FIELD_SELFTEST   2'h0
`define OPERATIONAL_STATUS_FIELD_WAIT       2'h1
`define OPERATIONAL_STATUS_FIELD_VALID      2'h2
`define OPERATIONAL_STATUS_FIELD_FATAL      2'h3
`define EVT_ALARM       0
`define EVT_FATAL       1
`define EVT_READY       2
`define EVT_TEST_DONE   3
`define EVT_W           4
`define CTRL_TEST_EN    0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EVT_MASK_RST    4'h0

// ----------------------------------------------------------------
// Widths in bits, and counts in noise samples
// ----------------------------------------------------------------
`define SAMPLE_W        8
`define RAND_W          16
`define REP_ALARM_CUT   8'h20
`define REP_FATAL_CUT   8'h40
`define WIN_CUT         10'h040
`define START_SAMPLES   11'h400

`endif

/* File: rtl/es_health_pkg.sv */
// Purpose: Types of the entropy source health and status control block.
// Assumes: Used with es_health_defines.svh.
// Notes:   One-hot state codes.
package es_health_pkg;

   typedef enum logic [3:0] {
      ST_SELFTEST = 4'h1,
      ST_WAIT     = 4'h2,
      ST_VALID    = 4'h4,
      ST_FATAL    = 4'h8
   } es_state_t;

endpackage

/* File: tb/es_health_ctrl_properties.sv */
// Purpose: Port-level assertions for es_health_ctrl.
// Assumes: The Avalon master holds each request until waitrequest_o is low.
// Notes:   Helper counters only watch ports; internal state stays private.
`timescale 1ns/1ps
`default_nettype none
`include "es_health_defines.svh"

module es_health_ctrl_properties (
   input wire logic                 mclk_i,
   input wire logic                 rst_n_i,
   input wire logic [4:0]           address_i,
   input wire logic                 read_i,
   input wire logic                 write_i,
   input wire logic [31:0]          writedata_i,
   input wire logic [31:0]          readdata_o,
   input wire logic                 waitrequest_o,
   input wire logic [`SAMPLE_W-1:0] noise_i,
   input wire logic                 noise_valid_i,
   input wire logic                 env_alarm_i,
   input wire logic                 irq_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   // ----------------------------------------------------------------
   // Helper state
   // ----------------------------------------------------------------
   logic        seed_rd;
   logic [3:0]  mask_q;
   logic [1:0]  env_q;
   logic [4:0]  samp_q;
   logic [10:0] boot_q;
   assign seed_rd = !waitrequest_o && read_i && address_i == `OFS_SEED;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_q <= 4'h0;
         env_q  <= 2'h0;
      end else begin
         if (!waitrequest_o && write_i && address_i == `OFS_EVT_MASK) mask_q <= writedata_i[3:0];
         // Second stage covers a read whose data was loaded before fatal
         env_q <= {env_q[0], env_q[0] | env_alarm_i};
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         samp_q <= 5'h00;
         boot_q <= 11'h000;
      end else begin
         if (seed_rd && readdata_o[31:30] == `OPERATIONAL_STATUS_FIELD_VALID) samp_q <= 5'h00;
         else if (noise_valid_i && samp_q != 5'h1F) samp_q <= samp_q + 5'h01;
         if (noise_valid_i && boot_q != 11'h7FF) boot_q <= boot_q + 11'h001;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   sequence s_taken;
      (read_i || write_i) && waitrequest_o;
   endsequence
   sequence s_answer;
      !waitrequest_o ##1 waitrequest_o;
   endsequence

   a_bus_answer: assert property (s_taken |=> s_answer)
      else $error("access not answered in two edges");
   a_no_stray_ack: assert property (!waitrequest_o |-> $past(read_i || write_i))
      else $error("waitrequest low without a request");
   a_unmapped_zero: assert property (!waitrequest_o && read_i && address_i > `OFS_NOISE
      |-> readdata_o == 32'h0000_0000)
      else $error("unmapped read returned data");
   a_data_only_valid: assert property (seed_rd && readdata_o[31:30] != `OPERATIONAL_STATUS_FIELD_VALID
      |-> readdata_o[15:0] == 16'h0000)
      else $error("random bits outside valid status");
   a_fatal_holds: assert property (seed_rd && env_q[1] |-> readdata_o[31:30] == `OPERATIONAL_STATUS_FIELD_FATAL)
      else $error("status left fatal after sensor error");
   a_mask_quiet_irq: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq_o)
      else $error("interrupt raised with all events masked");
   a_wipe_on_read: assert property (seed_rd && readdata_o[31:30] == `OPERATIONAL_STATUS_FIELD_VALID
      |-> samp_q >= 5'h0F)
      else $error("valid word returned again without new samples");
   a_boot_no_output: assert property (seed_rd && boot_q < `START_SAMPLES
      |-> readdata_o[31] == readdata_o[30])
      else $error("live status before start-up test finished");
endmodule // es_health_ctrl_properties

bind es_health_ctrl es_health_ctrl_properties es_health_ctrl_properties_i (.mclk_i, .rst_n_i,
   .address_i, .read_i, .write_i, .writedata_i, .readdata_o, .waitrequest_o, .noise_i,
   .noise_valid_i, .env_alarm_i, .irq_o);
`default_nettype wire

/* File: tb/es_health_ctrl_tb.sv */
// Purpose: Self-checking bench for es_health_ctrl.
// Assumes: Two-edge Avalon accesses; noise fed one sample per cycle.
// Notes:   Clean noise has odd parity, so every word gathered from it is all ones.
`timescale 1ns/1ps
`default_nettype none
`include "es_health_defines.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_errors++; \
   $display("BAD %s expected %h seen %h", nm, ex, got); end end

module es_health_ctrl_tb;
   logic        mclk_i        = 1'b0;
   logic        rst_n_i       = 1'b0;
   logic [4:0]  address_i     = 5'h00;
   logic        read_i        = 1'b0;
   logic        write_i       = 1'b0;
   logic [31:0] writedata_i   = 32'h0000_0000;
   logic [31:0] readdata_o;
   logic        waitrequest_o;
   logic [7:0]  noise_i       = 8'h00;
   logic        noise_valid_i = 1'b0;
   logic        env_alarm_i   = 1'b0;
   logic        irq_o;
   logic [31:0] rd;
   logic [6:0]  pat           = 7'h00;
   int          n_errors      = 0;
   int          checked       = 0;

   always #50 mclk_i = ~mclk_i;

   es_health_ctrl es_health_ctrl_i (.mclk_i, .rst_n_i, .address_i, .read_i, .write_i,
      .writedata_i, .readdata_o, .waitrequest_o, .noise_i, .noise_valid_i, .env_alarm_i, .irq_o);

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checked %0d, n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic do_reset();
      rst_n_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      rst_n_i <= 1'b1;
   endtask

   // Request held until the edge that samples waitrequest_o low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk_i);
      address_i <= a;
      writedata_i <= d;
      read_i <= !wr;
      write_i <= wr;
      do begin
         @(posedge mclk_i);
         k++;
      end while (waitrequest_o !== 1'b0 && k < 20);
      if (k >= 20) begin
         n_errors++;
         tally_and_finish();
      end
      rd = readdata_o;
      read_i <= 1'b0;
      write_i <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] ex);
      bus(1'b0, a, 32'h0000_0000);
      `CHK(nm, ex, rd)
   endtask

   // Same-value runs use even-parity bytes, never equal to a clean sample
   task automatic feed(input int n, input logic same, input logic [7:0] v);
      repeat (n) begin
         @(posedge mclk_i);
         noise_i <= same ? v : {pat, ~^pat};
         noise_valid_i <= 1'b1;
         pat = pat + 7'h01;
      end
      @(posedge mclk_i);
      noise_valid_i <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      do_reset();
      rdc("mask", `OFS_EVT_MASK, 32'h0000_0000);
      rdc("ctrl", `OFS_CTRL, 32'h0000_0000);
      bus(1'b1, `OFS_SEED, 32'hFFFF_FFFF);
      rdc("seed", `OFS_SEED, 32'h0000_0000);
      rdc("unmapped", 5'h14, 32'h0000_0000);
      rdc("noise", `OFS_NOISE, 32'h0000_0000);
      $display("test reset values done");

      feed(1023, 1'b0, 8'h00);
      rdc("seed", `OFS_SEED, 32'h0000_0000);
      feed(1, 1'b0, 8'h00);
      rdc("events", `OFS_EVT_STATUS, 32'h0000_0008);
      rdc("events", `OFS_EVT_STATUS, 32'h0000_0000);
      rdc("seed", `OFS_SEED, 32'h4000_0000);
      $display("test start-up done");

      feed(16, 1'b0, 8'h00);
      rdc("seed", `OFS_SEED, 32'h8000_FFFF);
      rdc("seed", `OFS_SEED, 32'h4000_0000);
      bus(1'b1, `OFS_EVT_MASK, 32'h0000_0004);
      repeat (2) @(posedge mclk_i);
      `CHK("irq", 1'b1, irq_o)
      rdc("events", `OFS_EVT_STATUS, 32'h0000_0004);
      repeat (2) @(posedge mclk_i);
      `CHK("irq", 1'b0, irq_o)
      $display("test word and wipe done");

      feed(16, 1'b0, 8'h00);
      bus(1'b1, `OFS_CTRL, 32'h0000_0001);
      rdc("seed", `OFS_SEED, 32'h4000_0000);
      feed(1, 1'b1, 8'hA5);
      rdc("noise", `OFS_NOISE, 32'h0000_00A5);
      bus(1'b1, `OFS_CTRL, 32'h0000_0000);
      $display("test raw noise port done");

      feed(32, 1'b1, 8'h5A);
      bus(1'b0, `OFS_SEED, 32'h0000_0000);
      `CHK("live", 1'b1, rd[31] ^ rd[30])
      feed(1, 1'b1, 8'h5A);
      rdc("seed", `OFS_SEED, 32'h0000_0000);
      bus(1'b0, `OFS_EVT_STATUS, 32'h0000_0000);
      `CHK("alarm", 1'b1, rd[0])
      feed(1024, 1'b0, 8'h00);
      rdc("seed", `OFS_SEED, 32'h4000_0000);
      $display("test repetition alarm done");

      @(posedge mclk_i);
      env_alarm_i <= 1'b1;
      @(posedge mclk_i);
      env_alarm_i <= 1'b0;
      rdc("seed", `OFS_SEED, 32'hC000_0000);
      feed(20, 1'b0, 8'h00);
      rdc("seed", `OFS_SEED, 32'hC000_0000);
      bus(1'b0, `OFS_EVT_STATUS, 32'h0000_0000);
      `CHK("fatal", 1'b1, rd[1])
      $display("test sensor fatal done");

      do_reset();
      rdc("seed", `OFS_SEED, 32'h0000_0000);
      feed(65, 1'b1, 8'h5A);
      rdc("seed", `OFS_SEED, 32'hC000_0000);
      $display("test start-up fatal done");

      // Reference 0x5A recurs 63 times per window; the second window
      // stays below its cutoff until its 64th hit only if the hit count was cleared between.
      do_reset();
      feed(1, 1'b1, 8'h5A);
      repeat (63) begin
         feed(1, 1'b1, 8'h3C);
         feed(1, 1'b1, 8'h5A);
      end
      feed(385, 1'b0, 8'h00);
      feed(1, 1'b1, 8'h5A);
      repeat (63) begin
         feed(1, 1'b1, 8'h3C);
         feed(1, 1'b1, 8'h5A);
      end
      rdc("seed", `OFS_SEED, 32'h0000_0000);
      feed(1, 1'b1, 8'h3C);
      feed(1, 1'b1, 8'h5A);
      rdc("seed", `OFS_SEED, 32'hC000_0000);
      $display("test window cutoff done");
      tally_and_finish();
   end
endmodule // es_health_ctrl_tb
`default_nettype wire
